// [verilog/dma_activation_source_select.sv]
// activation source selection and request generation for four dma channels
// assumes peripheral events are one-cycle pulses on mclk, request pins async
`default_nettype none
`include "dma_src_consts.svh"
module dma_activation_source_select
	import dma_src_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] factor_wr,
	input wire fact_t factor_wdata,
	input wire logic [3:0] chan_en,
	input wire logic [3:0] xfer_ack,
	input wire periph_ev_t periph_ev,
	input wire logic [1:0] external_transfer_request_pin,
	output logic [3:0][3:0] factor_rd,
	output logic [3:0] xfer_req,
	output logic [3:0] xfer_grant
);
	logic rst_q1;
	logic rst_sync;
	sel_state_t st;
	sel_state_t next_st;
	// pins idle high, so the synchroniser starts there and sees no false edge
	localparam sel_state_t ST_RESET = '{factor: {4{`FACT_RESET}},
		pending: 4'h0, first: 4'h0, en_d: 4'h0, grant: 4'h0,
		pin_s1: `PIN_IDLE, pin_s2: `PIN_IDLE, pin_d: `PIN_IDLE}; // [RULE8]

	// source decode shared by every channel
	function automatic logic src_hit(
		input fact_t f,
		input periph_ev_t ev,
		input logic is_b,
		input logic pin_low,
		input logic pin_rise,
		input logic first
	);
		logic hit;
		fact_t idx;
		hit = 1'b0;
		idx = f - `FACT_TIMER_BASE;
		case (f)
			`FACT_ADC_END: hit = ev.adc_end; // [RULE1]
			`FACT_PIN_EDGE: hit = is_b & (first ? pin_low : pin_rise); // [RULE4]
			`FACT_PIN_LEVEL: hit = is_b & pin_low; // [RULE5]
			`FACT_SER0_TX: hit = ev.serial_tx_done[0]; // [RULE2]
			`FACT_SER0_RX: hit = ev.serial_rx_done[0]; // [RULE2]
			`FACT_SER1_TX: hit = ev.serial_tx_done[1]; // [RULE2]
			`FACT_SER1_RX: hit = ev.serial_rx_done[1]; // [RULE2]
			default: begin
				// prohibited codes select nothing
				if (f >= `FACT_TIMER_BASE && f <= `FACT_TIMER_LAST) begin
					hit = ev.pulse_timer_capa[idx[2:0]]; // [RULE3]
				end
			end
		endcase
		return hit;
	endfunction

	// lowest set bit, channel 0a has the highest priority
	function automatic logic [3:0] lowest(input logic [3:0] v);
		return v & (~v + 4'h1);
	endfunction

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q1 <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_sync <= rst_q1;
		end
	end

	always_comb begin
		logic is_b;
		logic pin_low;
		logic pin_rise;
		logic hit;
		int p;
		is_b = 1'b0;
		pin_low = 1'b0;
		pin_rise = 1'b0;
		hit = 1'b0;
		p = 0;
		next_st = st;
		next_st.pin_s1 = external_transfer_request_pin;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_d = st.pin_s2;
		for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
			if (factor_wr[ch]) begin
				next_st.factor[ch] = factor_wdata; // [RULE8]
			end
			is_b = (ch % 2) == 1;
			p = ch / 2;
			pin_low = !st.pin_s2[p];
			pin_rise = st.pin_s2[p] & !st.pin_d[p];
			// the first transfer being taken must not re-arm from the same low
			hit = src_hit(st.factor[ch], periph_ev, is_b, pin_low, pin_rise,
				st.first[ch] & !xfer_ack[ch]); // [RULE4]
			next_st.en_d[ch] = chan_en[ch];
			// first request after enable is taken on a low level
			next_st.first[ch] = chan_en[ch] & ((!st.en_d[ch]) |
				(st.first[ch] & !xfer_ack[ch])); // [RULE4]
			if (is_b && st.factor[ch] == `FACT_PIN_LEVEL) begin
				next_st.pending[ch] = chan_en[ch] & hit; // [RULE5]
			end else begin
				// a new trigger wins over an acknowledge in the same cycle
				next_st.pending[ch] = chan_en[ch] &
					((st.pending[ch] & !xfer_ack[ch]) | hit);
			end
		end
		next_st.grant = lowest(next_st.pending); // [RULE6]
	end

	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign factor_rd = st.factor;
	assign xfer_req = st.pending;
	assign xfer_grant = st.grant;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_sync);

	// grant always names the highest priority pending channel
	property p_grant_priority;
		xfer_grant == (xfer_req & (~xfer_req + 4'h1));
	endproperty
	a_grant_priority: assert property (p_grant_priority) // [RULE6]
		else $error("grant is not the highest priority request");

	property p_grant_onehot;
		(|xfer_req) |-> $onehot(xfer_grant);
	endproperty
	a_grant_onehot: assert property (p_grant_onehot) // [RULE6]
		else $error("grant not one-hot while requests pend");

	for (genvar g = 0; g < `CHAN_COUNT; g++) begin : g_chk
		localparam int PI = g / 2;

		property p_factor_write;
			factor_wr[g] |=> factor_rd[g] == $past(factor_wdata);
		endproperty
		a_factor_write: assert property (p_factor_write) // [RULE8]
			else $error("factor field did not take the written value");

		property p_factor_hold;
			!factor_wr[g] |=> $stable(factor_rd[g]);
		endproperty
		a_factor_hold: assert property (p_factor_hold) // [RULE8]
			else $error("factor field changed without a write");

		property p_adc;
			(factor_rd[g] == `FACT_ADC_END && periph_ev.adc_end && chan_en[g]
				&& $past(chan_en[g])) |=> xfer_req[g];
		endproperty
		a_adc: assert property (p_adc) // [RULE1]
			else $error("conversion end did not raise a request");

		property p_serial;
			(factor_rd[g] == `FACT_SER1_RX && periph_ev.serial_rx_done[1]
				&& chan_en[g]) |=> xfer_req[g];
		endproperty
		a_serial: assert property (p_serial) // [RULE2]
			else $error("serial 1 receive done did not raise a request");

		property p_serial_tx0;
			(factor_rd[g] == `FACT_SER0_TX && periph_ev.serial_tx_done[0]
				&& chan_en[g]) |=> xfer_req[g];
		endproperty
		a_serial_tx0: assert property (p_serial_tx0) // [RULE2]
			else $error("serial 0 transmit done did not raise a request");

		property p_timer;
			(factor_rd[g] == 4'hd && periph_ev.pulse_timer_capa[5]
				&& chan_en[g]) |=> xfer_req[g];
		endproperty
		a_timer: assert property (p_timer) // [RULE3]
			else $error("timer 5 event did not raise a request");

		property p_disabled;
			!chan_en[g] |=> !xfer_req[g];
		endproperty
		a_disabled: assert property (p_disabled)
			else $error("request raised on a disabled channel");

		if (g % 2 == 1) begin : g_b
			sequence s_pin_rise;
				!st.first[g] && chan_en[g] && factor_rd[g] == `FACT_PIN_EDGE
					&& !st.pin_d[PI] && st.pin_s2[PI];
			endsequence
			sequence s_first_low;
				st.first[g] && chan_en[g] && factor_rd[g] == `FACT_PIN_EDGE
					&& !st.pin_s2[PI] && !xfer_ack[g];
			endsequence
			sequence s_first_taken;
				st.first[g] && xfer_ack[g] && factor_rd[g] == `FACT_PIN_EDGE
					&& !st.pin_s2[PI];
			endsequence

			property p_edge;
				s_pin_rise |=> xfer_req[g];
			endproperty
			a_edge: assert property (p_edge) // [RULE4]
				else $error("pin rising edge did not raise a request");

			property p_first_low;
				s_first_low |=> xfer_req[g];
			endproperty
			a_first_low: assert property (p_first_low) // [RULE4]
				else $error("first low level did not raise a request");

			property p_first_once;
				s_first_taken |=> !xfer_req[g];
			endproperty
			a_first_once: assert property (p_first_once) // [RULE4]
				else $error("held low level raised a second request");

			property p_level;
				(factor_rd[g] == `FACT_PIN_LEVEL && chan_en[g])
					|=> xfer_req[g] == ($past(chan_en[g])
					&& !$past(st.pin_s2[PI]));
			endproperty
			a_level: assert property (p_level) // [RULE5]
				else $error("level request does not follow the pin");
		end
	end
endmodule // dma_activation_source_select
`default_nettype wire

// [verilog/dma_src_consts.svh]
// constants for the dma activation source selector
// assumes one 50 MHz clock and a fixed channel order 0a, 0b, 1a, 1b
// Notes on behaviour
// RULE1: factor 0001 starts a transfer on converter conversion end.
// RULE2: factors 0100-0111 pick serial 0 tx, 0 rx, 1 tx, 1 rx done.
// RULE3: factors 1000-1101 pick timer channel 0-5 compare or capture a.
// RULE4: b channel factor 0010 uses pin rising edge; first request is low level.
// RULE5: b channel factor 0011 requests while the pin stays low.
// RULE6: shared sources allowed; highest priority channel is serviced first.
// RULE7: software never writes prohibited codes; a channels lack the pin.
// RULE8: each channel holds a 4-bit readable writable factor, reset to zero.
`ifndef DMA_SRC_CONSTS_SVH
`define DMA_SRC_CONSTS_SVH
`define FACT_RESET 4'h0
`define FACT_ADC_END 4'h1
`define FACT_PIN_EDGE 4'h2
`define FACT_PIN_LEVEL 4'h3
`define FACT_SER0_TX 4'h4
`define FACT_SER0_RX 4'h5
`define FACT_SER1_TX 4'h6
`define FACT_SER1_RX 4'h7
`define FACT_TIMER_BASE 4'h8
`define FACT_TIMER_LAST 4'hd
`define CHAN_COUNT 4
`define PIN_COUNT 2
`define PIN_IDLE 2'h3
`endif

// [verilog/dma_src_pkg.sv]
// types for the dma activation source selector
// assumes dma_src_consts.svh is on the include path
`default_nettype none
`include "dma_src_consts.svh"
package dma_src_pkg;
	typedef logic [3:0] fact_t;
	typedef struct packed {
		logic adc_end;
		logic [1:0] serial_tx_done;
		logic [1:0] serial_rx_done;
		logic [5:0] pulse_timer_capa;
	} periph_ev_t;
	typedef struct packed {
		logic [3:0][3:0] factor;
		logic [3:0] pending;
		logic [3:0] first;
		logic [3:0] en_d;
		logic [3:0] grant;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
		logic [1:0] pin_d;
	} sel_state_t;
endpackage
`default_nettype wire

// [sim/periph_model.sv]
// event sources and external requester facing the source selector
// assumes the bench holds fire for exactly one mclk cycle
`default_nettype none
module periph_model
	import dma_src_pkg::*;
(
	input wire logic fire,
	input wire logic fire_all,
	input wire fact_t code,
	input wire logic [1:0] pin_low,
	output var periph_ev_t periph_ev,
	output logic [1:0] external_transfer_request_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		periph_ev = fire_all ? '1 : '0;
		if (fire) begin
			case (code)
				4'h1: periph_ev.adc_end = 1'b1;
				4'h4: periph_ev.serial_tx_done[0] = 1'b1;
				4'h5: periph_ev.serial_rx_done[0] = 1'b1;
				4'h6: periph_ev.serial_tx_done[1] = 1'b1;
				4'h7: periph_ev.serial_rx_done[1] = 1'b1;
				default: if (code >= 4'h8 && code <= 4'hd) begin
					periph_ev.pulse_timer_capa[code - 4'h8] = 1'b1;
				end
			endcase
		end
	end
	// pins rest high on their pull-ups
	assign external_transfer_request_pin = ~pin_low;
endmodule // periph_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the dma activation source selector
// assumes the design, its package and periph_model are compiled first
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dma_src_pkg::*;
	logic mclk = 1'b0, arst_n = 1'b0, fire = 1'b0, fire_all = 1'b0;
	logic [3:0] factor_wr = 4'h0, chan_en = 4'h0, xfer_ack = 4'h0;
	logic [1:0] pin_low = 2'h0, pins;
	fact_t code = 4'h0, factor_wdata = 4'h0;
	periph_ev_t periph_ev;
	logic [3:0][3:0] factor_rd;
	logic [3:0] xfer_req, xfer_grant;
	wire logic [15:0] req_grant = {8'h0, xfer_req, xfer_grant};
	wire logic [15:0] req_only = {12'h0, xfer_req};
	int fails = 0, compares = 0;
	dma_activation_source_select dut (.mclk(mclk), .arst_n(arst_n),
		.factor_wr(factor_wr), .factor_wdata(factor_wdata),
		.chan_en(chan_en), .xfer_ack(xfer_ack), .periph_ev(periph_ev),
		.external_transfer_request_pin(pins), .factor_rd(factor_rd),
		.xfer_req(xfer_req), .xfer_grant(xfer_grant));
	periph_model peer (.fire(fire), .fire_all(fire_all), .code(code),
		.pin_low(pin_low), .periph_ev(periph_ev),
		.external_transfer_request_pin(pins));
	initial forever #10 mclk = ~mclk;
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] mask, input fact_t v);
		factor_wr = mask;
		factor_wdata = v;
		step(1);
		factor_wr = 4'h0;
		step(1);
	endtask
	task automatic pulse(input fact_t v);
		code = v;
		fire = 1'b1;
		step(1);
		fire = 1'b0;
		step(1);
	endtask
	task automatic ack(input logic [3:0] m);
		xfer_ack = m;
		step(1);
		xfer_ack = 4'h0;
		step(1);
	endtask
	task automatic print_verdict();
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_regs();
		chk(factor_rd, 16'h0);
		chk(req_grant, 16'h0);
		wr(4'h1, 4'h1);
		wr(4'h2, 4'h4);
		wr(4'h4, 4'h8);
		wr(4'h8, 4'hd);
		chk(factor_rd, 16'hd841);
	endtask
	task automatic t_shared();
		chan_en = 4'hf;
		for (int i = 1; i < 14; i++) begin
			if (i != 2 && i != 3) begin
				wr(4'hf, i[3:0]);
				pulse(i == 1 ? 4'h4 : 4'h1);
				chk(req_only, 16'h0);
				pulse(i[3:0]);
				chk(req_grant, 16'hf1);
				ack(4'h1);
				chk(req_grant, 16'he2);
				ack(4'he);
				chk(req_only, 16'h0);
			end
		end
	endtask
	task automatic t_refuse();
		fact_t bad[5] = '{4'h0, 4'h2, 4'h3, 4'he, 4'hf};
		foreach (bad[k]) begin
			wr(4'h5, bad[k]);
			wr(4'ha, (bad[k] == 4'h2 || bad[k] == 4'h3) ? 4'h0 : bad[k]);
			pin_low = 2'h3;
			fire_all = 1'b1;
			step(4);
			chk(req_only, 16'h0);
			pin_low = 2'h0;
			fire_all = 1'b0;
			step(3);
		end
	endtask
	task automatic t_level();
		chan_en = 4'h2;
		wr(4'h2, 4'h3);
		pin_low = 2'h1;
		step(2);
		chk(req_only, 16'h0);
		step(1);
		chk(req_grant, 16'h22);
		pin_low = 2'h0;
		step(3);
		chk(req_only, 16'h0);
	endtask
	task automatic t_edge();
		chan_en = 4'h0;
		wr(4'h8, 4'h2);
		pin_low = 2'h2;
		step(1);
		chan_en = 4'h8;
		step(5);
		chk(req_only, 16'h8);
		ack(4'h8);
		step(4);
		chk(req_only, 16'h0);
		pin_low = 2'h0;
		step(5);
		chk(req_grant, 16'h88);
		ack(4'h8);
	endtask
	initial begin
		step(6);
		arst_n = 1'b1;
		step(3);
		t_regs();
		t_shared();
		t_refuse();
		t_level();
		t_edge();
		print_verdict();
	end
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire
